// ### design/ufp_defs.svh
// register offsets, field positions, reset values and timing counts of the user flash page controller
`ifndef UFP_DEFS_SVH
`define UFP_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UFP_OFF_CMD 8'h00
`define UFP_OFF_CFG 8'h04
`define UFP_OFF_ADDR 8'h08
`define UFP_OFF_WDATA 8'h0C
`define UFP_OFF_STAT 8'h10
`define UFP_OFF_RDATA 8'h14

// ----------------------------------------
// command register bit positions
// ----------------------------------------
`define UFP_CMD_READ 0
`define UFP_CMD_WRITE 1
`define UFP_CMD_ERASE 2
`define UFP_CMD_PROG 3
`define UFP_CMD_UNPROT 4
`define UFP_CMD_DISCARD 5
`define UFP_CMD_BRESET 6

// ----------------------------------------
// byte address fields
// ----------------------------------------
`define UFP_SEC_HI 17
`define UFP_SEC_LO 12
`define UFP_PG_HI 11
`define UFP_PG_LO 7
`define UFP_BLK_HI 6
`define UFP_BLK_LO 4
`define UFP_BYTE_HI 3
`define UFP_AUX_BLK 4'h8
`define UFP_LAST_BLK 4'h8
`define UFP_PAGES_PER_SEC 12'h021
`define UFP_SPARE_IDX 12'h020

// ----------------------------------------
// reset values
// ----------------------------------------
`define UFP_CFG_RST 9'h000
`define UFP_ADDR_RST 18'h00000
`define UFP_WDATA_RST 32'h0000_0000
`define UFP_STAT_RST 2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define UFP_ARR_LAT 5
`define UFP_BLK_SW 4
`define UFP_CLK_MHZ 125
`define UFP_PROG_US 6800

`endif

// ### design/ufp_pkg.sv
// types shared by the user flash page controller
`default_nettype none
package ufp_pkg;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_READ = 3'h1,
        OP_WRITE = 3'h2,
        OP_ERASE = 3'h3,
        OP_PROG = 3'h4,
        OP_UNPROT = 3'h5,
        OP_DISCARD = 3'h6,
        OP_BRESET = 3'h7
    } ufp_op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_COPY_RD = 3'h1,
        ST_COPY_WR = 3'h2,
        ST_RELOAD = 3'h3,
        ST_BLK_SW = 3'h4,
        ST_ARR_RD = 3'h5,
        ST_COMMIT = 3'h6,
        ST_WAIT = 3'h7
    } ufp_state_e;

    typedef struct packed {
        logic lock;
        logic pipe;
        logic retarget;
        logic protect_set;
        logic guard;
        logic aux;
        logic spare;
        logic [1:0] width;
    } ufp_cfg_s;

    typedef struct packed {
        logic [5:0] sector;
        logic spare;
        logic [4:0] page;
    } ufp_page_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic commit;
        ufp_page_s page;
        logic [3:0] block;
        logic [127:0] wdata;
    } ufp_arr_req_s;

endpackage
`default_nettype wire

// ### design/ufp_user_flash_page_controller.sv
// user flash page controller: page buffer, block buffer, protection and program sequencing behind ahb-lite
// Operation
// RULE1 - 64 sectors of 33 pages, nine blocks
// RULE2 - data block 16 bytes, aux block 4
// RULE3 - address splits sector, page, block, byte
// RULE4 - spare or aux select masks address bits
// RULE5 - sector 0 spare page: writes error, reads zero
// RULE6 - page miss copies page, then merges write
// RULE7 - same block free, other block 4/5 busy
// RULE8 - page copy takes 55 busy cycles
// RULE9 - width code picks 1, 2 or 4 bytes
// RULE10 - wider transfers ignore low address bits
// RULE11 - user zeroes write data above width
// RULE12 - guard refuses other-page writes, status 11
// RULE13 - protected page refuses write/program/erase, 01
// RULE14 - program sets protection; unprotect then reprogram
// RULE15 - user raises lock request while using block
// RULE16 - simultaneous requests served by fixed priority
// RULE17 - requests accepted only while not busy
// RULE18 - status 00 success, sticky until next op
// RULE19 - program takes 6.8 ms, busy throughout
// RULE20 - program without retarget needs address match
// RULE21 - retarget programs addressed page unless protected
// RULE22 - program status 01 untouched, 11/10 errors
// RULE23 - synchronous to rising edge, active-low reset
// RULE24 - busy spans multi-cycle work, drops when ready
`timescale 1ns/1ns
`default_nettype none
`include "ufp_defs.svh"

module ufp_user_flash_page_controller
    import ufp_pkg::*;
#(
    parameter int unsigned PROG_CYC = `UFP_PROG_US * `UFP_CLK_MHZ
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // flash array
    output var ufp_arr_req_s arr_req,
    input wire logic [127:0] arr_rdata,
    input wire logic [1:0] arr_ecc,
    input wire logic arr_over_thr,
    // fabric indications
    output logic busy,
    output logic [1:0] status,
    output logic access_lock_request
);

    localparam int CW = $clog2(PROG_CYC + 1);

    // ----------------------------------------
    // state
    // ----------------------------------------
    ufp_cfg_s cfg_r;
    logic [17:0] addr_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic [31:0] hrdata_r;
    logic [1:0] status_r;
    logic busy_r;
    logic wr_ph_r;
    logic [7:0] wr_addr_r;
    ufp_state_e st_r;
    logic [CW-1:0] cnt_r;
    logic [3:0] blk_r;
    logic [127:0] cap_r;
    logic [1:0] ecc_acc_r;
    logic fin_wr_r;
    logic is_erase_r;
    logic prot_new_r;
    ufp_page_s tgt_r;
    ufp_arr_req_s arr_r;
    logic [127:0] pb_r [0:8]; // RULE1 RULE2
    logic [127:0] bb_r;
    logic [3:0] bb_idx_r;
    ufp_page_s pb_page_r;
    logic pb_valid_r;
    logic pb_mod_r;
    logic pb_unprot_r;
    logic prot_r [0:2111]; // RULE1

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] wmask(input logic [1:0] w);
        wmask = (w == 2'h0) ? 32'h0000_00FF : (w == 2'h1) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    endfunction

    function automatic logic [127:0] merge(input logic [127:0] old, input logic [3:0] off,
                                           input logic [1:0] w, input logic [31:0] d);
        logic [127:0] m;
        logic [127:0] v;
        m = {96'h0, wmask(w)} << {off, 3'h0};
        v = {96'h0, d} << {off, 3'h0};
        merge = (old & ~m) | (v & m);
    endfunction

    function automatic logic [31:0] pick(input logic [127:0] b, input logic [3:0] off, input logic [1:0] w);
        logic [127:0] s;
        s = b >> {off, 3'h0};
        pick = s[31:0] & wmask(w);
    endfunction

    // 33 protection slots per sector, spare page last
    function automatic logic [11:0] pidx(input ufp_page_s p);
        pidx = 12'(p.sector) * `UFP_PAGES_PER_SEC + (p.spare ? `UFP_SPARE_IDX : 12'(p.page));
    endfunction

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    wire logic ahb_go = hsel && hready && htrans[1];
    // registers stay frozen while busy, so an operation never sees its operands move
    wire logic reg_wr = wr_ph_r && !busy_r; // RULE17
    wire logic cmd_go = reg_wr && (wr_addr_r == `UFP_OFF_CMD);
    wire logic [31:0] rd_mux =
        (haddr == `UFP_OFF_CFG) ? {23'h0, cfg_r} :
        (haddr == `UFP_OFF_ADDR) ? {14'h0, addr_r} :
        (haddr == `UFP_OFF_WDATA) ? wdata_r :
        (haddr == `UFP_OFF_STAT) ? {29'h0, busy_r, status_r} :
        (haddr == `UFP_OFF_RDATA) ? rdata_r : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ph_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end
        else
        begin
            wr_ph_r <= ahb_go && hwrite;
            if (ahb_go)
                wr_addr_r <= haddr;
            if (ahb_go && !hwrite)
                hrdata_r <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_r <= `UFP_CFG_RST;
            addr_r <= `UFP_ADDR_RST;
            wdata_r <= `UFP_WDATA_RST;
        end
        else if (reg_wr)
        begin
            if (wr_addr_r == `UFP_OFF_CFG)
                cfg_r <= hwdata[8:0];
            if (wr_addr_r == `UFP_OFF_ADDR)
                addr_r <= hwdata[17:0];
            if (wr_addr_r == `UFP_OFF_WDATA)
                wdata_r <= hwdata;
        end
    end

    // ----------------------------------------
    // request priority and address decode
    // ----------------------------------------
    wire logic [6:0] cmd = hwdata[6:0];
    wire ufp_op_e op_sel =
        cmd[`UFP_CMD_BRESET] ? OP_BRESET :
        cmd[`UFP_CMD_READ] ? OP_READ :
        cmd[`UFP_CMD_WRITE] ? OP_WRITE :
        cmd[`UFP_CMD_ERASE] ? OP_ERASE :
        cmd[`UFP_CMD_PROG] ? OP_PROG :
        cmd[`UFP_CMD_UNPROT] ? OP_UNPROT :
        cmd[`UFP_CMD_DISCARD] ? OP_DISCARD : OP_NONE; // RULE16

    wire logic [3:0] lo_mask = (cfg_r.width == 2'h0) ? 4'hF : (cfg_r.width == 2'h1) ? 4'hE : 4'hC; // RULE9 RULE10
    wire logic [3:0] raw_byte = cfg_r.aux ? {2'h0, addr_r[1:0]} : addr_r[`UFP_BYTE_HI:0]; // RULE4
    wire logic [3:0] a_byte = raw_byte & lo_mask; // RULE10
    wire logic [3:0] a_blk = cfg_r.aux ? `UFP_AUX_BLK : {1'b0, addr_r[`UFP_BLK_HI:`UFP_BLK_LO]}; // RULE3 RULE4
    wire ufp_page_s a_page = '{sector: addr_r[`UFP_SEC_HI:`UFP_SEC_LO], spare: cfg_r.spare,
                               page: cfg_r.spare ? 5'h00 : addr_r[`UFP_PG_HI:`UFP_PG_LO]}; // RULE3 RULE4
    wire logic hit = pb_valid_r && (pb_page_r == a_page);
    wire logic sp0 = cfg_r.spare && (a_page.sector == 6'h00); // RULE5
    wire logic a_prot = prot_r[pidx(a_page)];
    wire logic prot_err = sp0 || (a_prot && !(hit && pb_unprot_r)); // RULE13 RULE5
    wire logic prog_err = prot_err || (!cfg_r.retarget && (!hit || !pb_mod_r)); // RULE20 RULE21
    wire logic erase_err = prot_err || (!cfg_r.retarget && !hit && cfg_r.guard && pb_mod_r);
    wire logic [127:0] merged = merge(pb_r[a_blk], a_byte, cfg_r.width, wdata_r); // RULE6
    wire logic [CW-1:0] sw_last = cfg_r.pipe ? CW'(`UFP_BLK_SW) : CW'(`UFP_BLK_SW - 1); // RULE7
    wire logic wr_hit = cmd_go && (st_r == ST_IDLE) && (op_sel == OP_WRITE) && hit && !prot_err
                        && (a_blk == bb_idx_r); // RULE7
    wire logic blk_done = (st_r == ST_BLK_SW) && (cnt_r == sw_last);
    wire logic merge_we = wr_hit || blk_done || ((st_r == ST_RELOAD) && fin_wr_r);
    wire logic wait_done = (st_r == ST_WAIT) && (cnt_r == CW'(PROG_CYC - 1));

    // ----------------------------------------
    // page buffer and protection storage
    // ----------------------------------------
    always_ff @(posedge hclk)
    begin
        if (st_r == ST_COPY_WR)
            pb_r[blk_r] <= cap_r; // RULE6 RULE8
        else if (merge_we)
            pb_r[a_blk] <= merged; // RULE6
    end

    // protection lives in the array on silicon; here it is volatile and cleared by reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 2112; i++)
                prot_r[i] <= 1'b0;
        end
        else if (wait_done && !is_erase_r)
            prot_r[pidx(tgt_r)] <= prot_new_r; // RULE14
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= ST_IDLE; // RULE23
            busy_r <= 1'b0;
            status_r <= `UFP_STAT_RST;
            rdata_r <= 32'h0000_0000;
            cnt_r <= '0;
            blk_r <= 4'h0;
            cap_r <= '0;
            ecc_acc_r <= 2'h0;
            fin_wr_r <= 1'b0;
            is_erase_r <= 1'b0;
            prot_new_r <= 1'b0;
            tgt_r <= '0;
            arr_r <= '0;
            bb_r <= '0;
            bb_idx_r <= 4'h0;
            pb_page_r <= '0;
            pb_valid_r <= 1'b0;
            pb_mod_r <= 1'b0;
            pb_unprot_r <= 1'b0;
        end
        else
        begin
            arr_r.rd <= 1'b0;
            arr_r.wr <= 1'b0;
            arr_r.commit <= 1'b0;
            if (merge_we)
            begin
                bb_r <= merged;
                bb_idx_r <= a_blk;
            end
            unique case (st_r)
            ST_IDLE:
                if (cmd_go)
                begin
                    unique case (op_sel)
                    OP_BRESET:
                    begin
                        pb_valid_r <= 1'b0;
                        pb_mod_r <= 1'b0;
                        pb_unprot_r <= 1'b0;
                        status_r <= 2'h0;
                    end
                    OP_READ:
                        if (sp0 || hit)
                        begin
                            rdata_r <= sp0 ? 32'h0000_0000 : pick(pb_r[a_blk], a_byte, cfg_r.width); // RULE5
                            status_r <= 2'h0;
                        end
                        else
                        begin
                            st_r <= ST_ARR_RD;
                            busy_r <= 1'b1;
                            cnt_r <= '0;
                            arr_r.rd <= 1'b1;
                            arr_r.page <= a_page;
                            arr_r.block <= a_blk;
                        end
                    OP_WRITE:
                        if (prot_err)
                            status_r <= 2'h1; // RULE13 RULE5
                        else if (!hit && cfg_r.guard && pb_mod_r)
                            status_r <= 2'h3; // RULE12
                        else if (!hit)
                        begin
                            st_r <= ST_COPY_RD; // RULE6
                            busy_r <= 1'b1; // RULE24
                            fin_wr_r <= 1'b1;
                            cnt_r <= '0;
                            blk_r <= 4'h0;
                            ecc_acc_r <= 2'h0;
                            pb_valid_r <= 1'b0;
                            pb_page_r <= a_page;
                            arr_r.rd <= 1'b1;
                            arr_r.page <= a_page;
                            arr_r.block <= 4'h0;
                        end
                        else if (a_blk == bb_idx_r)
                        begin
                            pb_mod_r <= 1'b1; // RULE7
                            status_r <= 2'h0; // RULE18
                        end
                        else
                        begin
                            st_r <= ST_BLK_SW; // RULE7
                            busy_r <= 1'b1;
                            cnt_r <= '0;
                        end
                    OP_ERASE, OP_PROG:
                        if ((op_sel == OP_PROG) ? prog_err : erase_err)
                            status_r <= 2'h1; // RULE13 RULE20 RULE22
                        else
                        begin
                            st_r <= ST_COMMIT; // RULE19
                            busy_r <= 1'b1;
                            is_erase_r <= (op_sel == OP_ERASE);
                            prot_new_r <= cfg_r.protect_set; // RULE14
                            tgt_r <= a_page; // RULE21
                            blk_r <= 4'h0;
                            arr_r.wr <= 1'b1;
                            arr_r.page <= a_page;
                            arr_r.block <= 4'h0;
                            arr_r.wdata <= (op_sel == OP_ERASE) ? 128'h0 : pb_r[0];
                        end
                    OP_UNPROT:
                        if (sp0)
                            status_r <= 2'h1; // RULE5
                        else if (hit)
                        begin
                            pb_unprot_r <= 1'b1; // RULE14
                            status_r <= 2'h0;
                        end
                        else if (cfg_r.guard && pb_mod_r)
                            status_r <= 2'h3;
                        else
                        begin
                            st_r <= ST_COPY_RD;
                            busy_r <= 1'b1;
                            fin_wr_r <= 1'b0;
                            cnt_r <= '0;
                            blk_r <= 4'h0;
                            ecc_acc_r <= 2'h0;
                            pb_valid_r <= 1'b0;
                            pb_page_r <= a_page;
                            arr_r.rd <= 1'b1;
                            arr_r.page <= a_page;
                            arr_r.block <= 4'h0;
                        end
                    OP_DISCARD:
                    begin
                        pb_mod_r <= 1'b0;
                        pb_unprot_r <= 1'b0;
                        status_r <= 2'h0;
                    end
                    OP_NONE:
                        status_r <= status_r; // RULE18
                    endcase
                end
            ST_COPY_RD:
                if (cnt_r == CW'(`UFP_ARR_LAT - 1))
                begin
                    cap_r <= arr_rdata; // RULE8
                    if (arr_ecc > ecc_acc_r)
                        ecc_acc_r <= arr_ecc;
                    st_r <= ST_COPY_WR;
                end
                else
                    cnt_r <= cnt_r + CW'(1);
            ST_COPY_WR:
                if (blk_r == `UFP_LAST_BLK)
                    st_r <= ST_RELOAD; // RULE8
                else
                begin
                    st_r <= ST_COPY_RD;
                    cnt_r <= '0;
                    blk_r <= blk_r + 4'h1;
                    arr_r.rd <= 1'b1;
                    arr_r.block <= blk_r + 4'h1;
                end
            ST_RELOAD:
            begin
                st_r <= ST_IDLE;
                busy_r <= 1'b0; // RULE24
                pb_valid_r <= 1'b1;
                if (fin_wr_r)
                begin
                    pb_mod_r <= 1'b1;
                    status_r <= 2'h0;
                end
                else
                begin
                    bb_r <= pb_r[a_blk];
                    bb_idx_r <= a_blk;
                    pb_unprot_r <= 1'b1;
                    status_r <= ecc_acc_r;
                end
            end
            ST_BLK_SW:
                if (blk_done)
                begin
                    st_r <= ST_IDLE;
                    busy_r <= 1'b0; // RULE24
                    pb_mod_r <= 1'b1;
                    status_r <= 2'h0;
                end
                else
                    cnt_r <= cnt_r + CW'(1);
            ST_ARR_RD:
                if (cnt_r == CW'(`UFP_ARR_LAT - 1))
                begin
                    st_r <= ST_IDLE;
                    busy_r <= 1'b0;
                    rdata_r <= pick(arr_rdata, a_byte, cfg_r.width);
                    status_r <= arr_ecc;
                end
                else
                    cnt_r <= cnt_r + CW'(1);
            ST_COMMIT:
                if (blk_r == `UFP_LAST_BLK)
                begin
                    st_r <= ST_WAIT;
                    cnt_r <= '0;
                    arr_r.commit <= 1'b1;
                end
                else
                begin
                    blk_r <= blk_r + 4'h1;
                    arr_r.wr <= 1'b1;
                    arr_r.block <= blk_r + 4'h1;
                    arr_r.wdata <= is_erase_r ? 128'h0 : pb_r[blk_r + 4'h1];
                end
            ST_WAIT:
                // long program time; shorten PROG_CYC in simulation
                if (wait_done)
                begin
                    st_r <= ST_IDLE;
                    busy_r <= 1'b0; // RULE19 RULE24
                    status_r <= arr_over_thr ? 2'h3 : (arr_ecc == 2'h2) ? 2'h2 : 2'h0; // RULE22
                    if (!is_erase_r)
                    begin
                        pb_page_r <= tgt_r;
                        pb_valid_r <= 1'b1;
                        pb_mod_r <= 1'b0;
                        pb_unprot_r <= 1'b0;
                    end
                end
                else
                    cnt_r <= cnt_r + CW'(1);
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign arr_req = arr_r;
    assign busy = busy_r; // RULE17
    assign status = status_r; // RULE18
    assign access_lock_request = cfg_r.lock; // RULE15

endmodule
`default_nettype wire

// ### test/ufp_array_model.sv
// flash array model: answers a block read four edges after the request
`timescale 1ns/1ns
`default_nettype none
module ufp_array_model
    import ufp_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // array side
    input wire ufp_arr_req_s arr_req,
    input wire logic thr_in,
    output logic [127:0] arr_rdata,
    output logic [1:0] arr_ecc,
    output logic arr_over_thr
);
    logic [3:0] sh_r;
    logic [15:0] tag_r;
    wire logic [127:0] blk_w = {4{tag_r, 16'hA5C3}};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sh_r <= 4'h0;
        else
            sh_r <= {sh_r[2:0], arr_req.rd};
    end
    always_ff @(posedge hclk)
    begin
        if (arr_req.rd)
            tag_r <= {arr_req.page, arr_req.block};
    end
    // outside the answer cycle the lines carry the inverse, never a stale match
    assign arr_rdata = sh_r[3] ? blk_w : ~blk_w;
    assign arr_ecc = 2'h0;
    assign arr_over_thr = thr_in;
endmodule
`default_nettype wire

// ### test/ufp_chk.sv
// port assertions of the user flash page controller
`timescale 1ns/1ns
`default_nettype none
module ufp_chk
    import ufp_pkg::*;
#(
    parameter int unsigned PROG_CYC = 16
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // watched outputs
    input wire ufp_arr_req_s arr_req,
    input wire logic busy,
    input wire logic [1:0] status
);
    int unsigned cnt_r;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_r <= 0;
        else
            cnt_r <= busy ? cnt_r + 1 : 0;
    end
    busy_len_a: assert property ($fell(busy) |-> cnt_r inside {4, 5, 55, 9 + PROG_CYC})
        else $error("busy length");
    rd_gap_a: assert property (arr_req.rd |=> !arr_req.rd [*5]) else $error("read gap");
    rd_busy_a: assert property (arr_req.rd |-> busy) else $error("read not busy");
    commit_busy_a: assert property (arr_req.commit |-> busy [*8]) else $error("commit busy");
    wr_seq_a: assert property ($rose(arr_req.wr) |-> arr_req.block == 4'h0 ##8
        (arr_req.wr && arr_req.block == 4'h8) ##1 arr_req.commit) else $error("program order");
    stat_hold_a: assert property (busy && $past(busy) |-> $stable(status)) else $error("status moved");
    spare_zero_a: assert property (!(arr_req.rd && arr_req.page.sector == 6'h00 && arr_req.page.spare))
        else $error("spare read");
    blk_range_a: assert property (arr_req.rd |-> arr_req.block <= 4'h8) else $error("block range");
    cover property ($fell(busy) && cnt_r == 55);
    cover property ($fell(busy) && cnt_r == 4);
    cover property (arr_req.commit);
endmodule
bind ufp_user_flash_page_controller ufp_chk #(.PROG_CYC(PROG_CYC)) chk_u (.hclk(hclk), .hresetn(hresetn),
    .arr_req(arr_req), .busy(busy), .status(status));
`default_nettype wire

// ### test/ufp_user_flash_page_controller_bench.sv
// self-checking bench of the user flash page controller
`timescale 1ns/1ns
`default_nettype none
module ufp_user_flash_page_controller_bench;
    import ufp_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, thr = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, hrdata, q, d, mk;
    logic hreadyout, hresp, busy, lock, othr;
    logic [1:0] status, ecc;
    logic [127:0] rdat;
    ufp_arr_req_s req;
    logic [17:0] a;
    logic [31:0] m [int];
    int n_errors = 0, checks = 0, cyc = 0, seed = 88, w, sh;
    always #4 hclk = ~hclk;
    ufp_user_flash_page_controller #(.PROG_CYC(16)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .arr_req(req), .arr_rdata(rdat),
        .arr_ecc(ecc), .arr_over_thr(othr), .busy(busy), .status(status), .access_lock_request(lock));
    ufp_array_model arr_u (.hclk(hclk), .hresetn(hresetn), .arr_req(req), .thr_in(thr), .arr_rdata(rdat),
        .arr_ecc(ecc), .arr_over_thr(othr));
    function automatic logic [31:0] ref_w(input logic [17:0] ad);
        return m.exists(ad[17:2]) ? m[ad[17:2]] : {ad[17:12], 1'b0, ad[11:7], 1'b0, ad[6:4], 16'hA5C3};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // writes land only while idle, so every command waits out busy
    task op(input logic [7:0] c, input logic [17:0] ad, input logic [7:0] cmd);
        xfer(1, 8'h04, {23'h0, 1'b1, c});
        xfer(1, 8'h08, {14'h0, ad});
        xfer(1, 8'h00, {24'h0, cmd});
        do @(posedge hclk); while (busy !== 1'b0);
    endtask
    task sts(input logic [1:0] e);
        xfer(0, 8'h10, 0);
        chk({q[29:0], status}, {28'h0, e, e});
        chk({30'h0, lock, hresp}, 32'h0000_0002);
    endtask
    task rdw(input logic [17:0] ad);
        op(8'h02, ad, 8'h01);
        xfer(0, 8'h14, 0);
        chk(q, ref_w(ad));
    endtask
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        xfer(0, 8'h18, 0);
        chk(q, 0);
        op(8'h06, 18'h00000, 8'h01);
        xfer(0, 8'h14, 0);
        chk(q, 0);
        op(8'h06, 18'h00000, 8'h02);
        sts(2'h1);
        rdw(18'h05280);
        a = 18'h02100;
        for (w = 0; w < 4; w++)
        begin
            a[6:0] = 7'($random(seed));
            mk = w == 0 ? 32'hFF : w == 1 ? 32'hFFFF : 32'hFFFFFFFF;
            sh = w == 0 ? 8 * a[1:0] : w == 1 ? 16 * a[1] : 0;
            d = $random(seed) & mk;
            m[a[17:2]] = ref_w(a) & ~(mk << sh) | (d << sh);
            xfer(1, 8'h0C, d);
            op(8'(w) | {w[0], 7'h00}, a, 8'h02);
            sts(2'h0);
            rdw(a);
        end
        op(8'h12, 18'h03000, 8'h0A);
        sts(2'h3);
        rdw(18'h03000);
        op(8'h22, a, 8'h08);
        sts(2'h0);
        op(8'h02, a, 8'h04);
        sts(2'h1);
        op(8'h02, a, 8'h02);
        sts(2'h1);
        op(8'h02, 18'h07000, 8'h08);
        sts(2'h1);
        op(8'h02, a, 8'h10);
        op(8'h02, a, 8'h02);
        sts(2'h0);
        thr <= 1;
        op(8'h02, a, 8'h08);
        sts(2'h3);
        thr <= 0;
        op(8'h02, a, 8'h02);
        sts(2'h0);
        op(8'h42, 18'h07000, 8'h08);
        sts(2'h0);
        op(8'h06, 18'h00000, 8'h02);
        hresetn <= 0;
        @(posedge hclk);
        hresetn <= 1;
        xfer(0, 8'h10, 0);
        chk({q[30:0], lock}, 0);
        finish_test;
    end
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            finish_test;
        end
    end
    task finish_test;
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
endmodule
`default_nettype wire
